// ### ssc_pkg.sv
// Package of constants and types for the sync and stack configuration block
package ssc_pkg;
    // -------------------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------------------
    localparam logic [7:0] SSC_CMD_CLOCK_SYNC = 8'he4;
    localparam logic [7:0] SSC_CMD_PHASE_STACK = 8'hec;
    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int SSC_ROLE_HI = 7;
    localparam int SSC_ROLE_LO = 6;
    localparam int SSC_POL_BIT = 5;
    localparam int SSC_FIX_HI = 4;
    localparam int SSC_FIX_HI_W = 5;
    localparam int SSC_FC_HI = 3;
    // -------------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------------
    localparam logic [4:0] SSC_FIX_VAL = 5'h10;
    localparam logic [7:0] SSC_SYNC_RST = 8'h50;
    localparam logic [3:0] SSC_FC_RST = 4'h0;
    localparam logic [3:0] SSC_FC_MAX = 4'h3;
    localparam logic [3:0] SSC_SLOT_VAL = 4'h0;
    localparam logic [7:0] SSC_HI_BYTE_VAL = 8'h00;
    // -------------------------------------------------------------------------
    // Timing counts
    // -------------------------------------------------------------------------
    localparam int SSC_CLK_MHZ = 40;
    localparam int SSC_FSW_KHZ = 500;
    localparam int SSC_PER_NOM_I = (SSC_CLK_MHZ * 1000) / SSC_FSW_KHZ;
    localparam logic [11:0] SSC_PER_NOM = 12'(SSC_PER_NOM_I);
    // Slow period for 70% of nominal frequency
    localparam logic [11:0] SSC_PER_SLOW = 12'((SSC_PER_NOM_I * 100) / 70);
    // Slowest accepted external period: 75% of nominal frequency
    localparam logic [11:0] SSC_PER_FOLLOW = 12'((SSC_PER_NOM_I * 100) / 75);
    localparam logic [11:0] SSC_PULSE_W = 12'(SSC_PER_NOM_I / 2);

    typedef enum logic [1:0] {
        SSC_ROLE_OFF,
        SSC_ROLE_OUT,
        SSC_ROLE_IN,
        SSC_ROLE_AUTO
    } ssc_role_type;
endpackage

// ### ssc_edge_det.sv
// Two-stage synchroniser with edge detection for the sync pin
`timescale 1ns/100ps
`default_nettype none
module ssc_edge_det
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Pin and edge outputs
    input wire logic pin_in,
    input wire logic pol_rise,
    output logic level,
    output logic edge_seen
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic edg;
    } ssc_edge_state_type;
    ssc_edge_state_type st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.s1 = pin_in;
            st_nxt.s2 = st_r.s1;
            st_nxt.s3 = st_r.s2;
            // Selected edge only
            st_nxt.edg = pol_rise ? (st_r.s2 & ~st_r.s3) : (~st_r.s2 & st_r.s3); // R02
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.s2;
    assign edge_seen = st_r.edg;
endmodule // ssc_edge_det
`default_nettype wire

// ### ssc_sync_stack_config.sv
// Sync role and phase stack configuration registers with sync engine
// Summary of operation
// R01: Role field decodes off, out, in, auto
// R02: Polarity bit picks falling or rising edge
// R03: Low five bits fixed, reset 10000b
// R04: Unsupported clock sync write flags invalid data
// R05: Auto mode samples pin at enable
// R06: High or fast toggling pin selects follow
// R07: Low quiet pin selects drive
// R08: Follower always follows, faults on lost clock
// R09: Host should choose drive without external source
// R10: Follow-to-drive at low limit keeps frequency
// R11: Follow-to-drive during fault runs at seventy percent
// R12: Single byte access, applied immediately
// R13: Upper byte of stack word reads zero
// R14: Controller slot reads zero
// R15: Follower count 0..3, others invalid
// R16: Stack word writable only while disabled
// R17: Standalone at power-up disables backchannel
// R18: Later multi-phase change waits for power-up
// R19: Multi-phase power-up allows live changes
// R20: Host must store and cycle analog supply
// R21: Drive role emits one pulse per period
`timescale 1ns/100ps
`default_nettype none
module ssc_sync_stack_config
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Command port from the PMBus engine
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_word,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_ack,
    output logic invalid_data,
    // Converter status
    input wire logic conv_enable,
    input wire logic is_follower,
    input wire logic at_low_limit,
    // Strapped stack value at power-up
    input wire logic [3:0] strap_follower_count,
    // Sync pin
    input wire logic sync_in,
    input wire logic sync_high,
    output logic sync_out,
    output logic sync_oe,
    // Status
    output logic sync_fault,
    output logic following,
    output logic slow_osc,
    output logic backchannel_en,
    output logic [3:0] follower_count
);
    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sync_cfg;
        logic [3:0] fcount;
        logic [15:0] rdata;
        logic ack;
        logic inv;
        logic init_done;
        logic bc_en;
        logic en_d;
        logic auto_follow;
        logic follow;
        logic slow;
        logic fault;
        logic [11:0] per_cnt;
        logic [11:0] gap_cnt;
        logic saw_edge;
        logic fast_toggle;
        logic sout;
        logic soe;
    } ssc_state_type;
    ssc_state_type st_r, st_nxt;

    logic pin_level;
    logic pin_edge;

    function automatic logic sync_val_ok(input logic [7:0] v);
        return v[SSC_FIX_HI:0] == SSC_FIX_VAL;
    endfunction

    function automatic logic fc_ok(input logic [3:0] v);
        return v <= SSC_FC_MAX;
    endfunction

    function automatic logic is_sync_cmd(input logic [7:0] c);
        return c == SSC_CMD_CLOCK_SYNC;
    endfunction

    function automatic logic is_stack_cmd(input logic [7:0] c);
        return c == SSC_CMD_PHASE_STACK;
    endfunction

    // -------------------------------------------------------------------------
    // Sync pin synchroniser
    // -------------------------------------------------------------------------
    ssc_edge_det u_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(sync_in),
        .pol_rise(st_r.sync_cfg[SSC_POL_BIT]),
        .level(pin_level),
        .edge_seen(pin_edge)
    );

    // Comparator flag kept spare: the synchronised level does the job
    logic unused_high;
    assign unused_high = sync_high;

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        ssc_role_type role;
        logic rise_en;
        logic follow_now;
        logic want_follow;
        logic [11:0] per;
        role = ssc_role_type'(st_r.sync_cfg[SSC_ROLE_HI:SSC_ROLE_LO]); // R01
        rise_en = 1'b0;
        follow_now = 1'b0;
        want_follow = 1'b0;
        per = SSC_PER_NOM;
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.ack = 1'b0;
            st_nxt.inv = 1'b0;
            st_nxt.en_d = conv_enable;
            rise_en = conv_enable & ~st_r.en_d;

            // ------------------------------------------------------------
            // Power-up capture of stack value
            // ------------------------------------------------------------
            if (!st_r.init_done) begin
                st_nxt.init_done = 1'b1;
                st_nxt.fcount = fc_ok(strap_follower_count) ?
                    strap_follower_count : SSC_FC_RST;
                // Backchannel only if powered up multi-phase
                st_nxt.bc_en = fc_ok(strap_follower_count) &&
                    (strap_follower_count != SSC_FC_RST); // R17 R18 R19
            end

            // ------------------------------------------------------------
            // Register writes
            // ------------------------------------------------------------
            if (cmd_wr && is_sync_cmd(cmd_code)) begin
                st_nxt.ack = 1'b1;
                if (!cmd_word && sync_val_ok(cmd_wdata[7:0])) begin // R12
                    st_nxt.sync_cfg = cmd_wdata[7:0]; // R03 R12
                end else begin
                    st_nxt.inv = 1'b1; // R04
                end
            end
            if (cmd_wr && is_stack_cmd(cmd_code)) begin
                st_nxt.ack = 1'b1;
                if (conv_enable) begin
                    st_nxt.inv = 1'b1; // R16
                end else if (cmd_word && fc_ok(cmd_wdata[SSC_FC_HI:0]) &&
                             cmd_wdata[15:4] == 12'h000) begin
                    st_nxt.fcount = cmd_wdata[SSC_FC_HI:0]; // R15 R19
                end else begin
                    st_nxt.inv = 1'b1; // R15
                end
            end

            // ------------------------------------------------------------
            // Register reads
            // ------------------------------------------------------------
            if (cmd_rd) begin
                st_nxt.ack = 1'b1;
                if (is_sync_cmd(cmd_code)) begin
                    st_nxt.rdata = {SSC_HI_BYTE_VAL, st_r.sync_cfg}; // R12
                end else if (is_stack_cmd(cmd_code)) begin
                    st_nxt.rdata = {SSC_HI_BYTE_VAL, SSC_SLOT_VAL,
                                    st_r.fcount}; // R13 R14
                end else begin
                    // Unmapped codes read zero and are refused
                    st_nxt.rdata = 16'h0000;
                    st_nxt.inv = 1'b1;
                end
            end

            // ------------------------------------------------------------
            // Toggle detection: edges spaced no wider than follow period
            // ------------------------------------------------------------
            if (st_r.soe) begin
                // Own pulses on the pin must not look like an outside clock
                st_nxt.fast_toggle = 1'b0;
                st_nxt.saw_edge = 1'b0;
            end else if (pin_edge) begin
                st_nxt.fast_toggle = st_r.saw_edge &&
                    (st_r.gap_cnt <= SSC_PER_FOLLOW); // R06
                st_nxt.saw_edge = 1'b1;
                st_nxt.gap_cnt = 12'h000;
            end else if (st_r.gap_cnt > SSC_PER_SLOW) begin
                st_nxt.fast_toggle = 1'b0;
                st_nxt.saw_edge = 1'b0;
            end else begin
                st_nxt.gap_cnt = st_r.gap_cnt + 12'h001;
            end

            // ------------------------------------------------------------
            // Auto detection at enable
            // ------------------------------------------------------------
            if (rise_en) begin
                st_nxt.auto_follow =
                    pin_level | st_r.fast_toggle; // R05 R06 R07
            end

            // ------------------------------------------------------------
            // Role selection
            // ------------------------------------------------------------
            case (role)
                SSC_ROLE_IN: want_follow = 1'b1;
                SSC_ROLE_AUTO: want_follow = rise_en ?
                    (pin_level | st_r.fast_toggle) : st_r.auto_follow;
                SSC_ROLE_OUT: want_follow = 1'b0;
                SSC_ROLE_OFF: want_follow = 1'b0;
                default: want_follow = 1'b0;
            endcase
            // Stack followers always follow the outside clock
            follow_now = want_follow | is_follower; // R08

            // ------------------------------------------------------------
            // Lost clock fault in follower mode
            // ------------------------------------------------------------
            // Sticky until the output is disabled
            if (!conv_enable) begin
                st_nxt.fault = 1'b0;
            end else if (is_follower && !st_nxt.fast_toggle) begin
                st_nxt.fault = 1'b1; // R08
            end

            // ------------------------------------------------------------
            // Follow-to-drive switch keeps slow rate
            // ------------------------------------------------------------
            // The role field decides here, so a forced follower still slows
            if (st_r.follow && !want_follow && conv_enable &&
                (at_low_limit || st_r.fault)) begin
                st_nxt.slow = 1'b1; // R10 R11
            end
            if (!conv_enable) begin
                st_nxt.slow = 1'b0;
            end
            st_nxt.follow = follow_now;

            // ------------------------------------------------------------
            // Sync out pulse generator
            // ------------------------------------------------------------
            per = st_r.slow ? SSC_PER_SLOW : SSC_PER_NOM;
            // Auto role keeps off the pin until the enable decision
            st_nxt.soe = !follow_now && role != SSC_ROLE_OFF &&
                (role != SSC_ROLE_AUTO || conv_enable); // R21 R05
            if (st_r.per_cnt >= per - 12'h001) begin
                st_nxt.per_cnt = 12'h000;
            end else begin
                st_nxt.per_cnt = st_r.per_cnt + 12'h001;
            end
            // Leading active edge at period start
            st_nxt.sout = (st_nxt.per_cnt < SSC_PULSE_W) ^
                ~st_r.sync_cfg[SSC_POL_BIT]; // R21 R02
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.sync_cfg <= SSC_SYNC_RST; // R03
            st_r.fcount <= SSC_FC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign cmd_rdata = st_r.rdata;
    assign cmd_ack = st_r.ack;
    assign invalid_data = st_r.inv;
    assign sync_out = st_r.sout;
    assign sync_oe = st_r.soe;
    assign sync_fault = st_r.fault;
    assign following = st_r.follow;
    assign slow_osc = st_r.slow;
    assign backchannel_en = st_r.bc_en;
    assign follower_count = st_r.fcount;
endmodule // ssc_sync_stack_config
`default_nettype wire

// ### ssc_monitor.sv
// Port checker for the sync and stack configuration block
`timescale 1ns/100ps
`default_nettype none
module ssc_monitor
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Command port
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_ack,
    input wire logic invalid_data,
    // Status
    input wire logic conv_enable,
    input wire logic is_follower,
    input wire logic sync_oe,
    input wire logic sync_fault,
    input wire logic following,
    input wire logic backchannel_en,
    input wire logic [3:0] follower_count
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    logic wr_e4;
    logic wr_ec;
    assign req = clk_en && (cmd_wr || cmd_rd);
    assign wr_e4 = req && cmd_wr && cmd_code == SSC_CMD_CLOCK_SYNC;
    assign wr_ec = req && cmd_wr && cmd_code == SSC_CMD_PHASE_STACK;
    a_ack_timing: assert property (req |=> cmd_ack)
        else $error("ack missing");
    a_ack_cause: assert property (cmd_ack |-> $past(req))
        else $error("ack without request");
    a_inv_paired: assert property (invalid_data |-> cmd_ack)
        else $error("invalid without ack");
    a_fix_refused: assert property (wr_e4 && cmd_wdata[4:0] != SSC_FIX_VAL
        |=> invalid_data) else $error("bad low bits taken");
    a_stack_locked: assert property (wr_ec && conv_enable |=> invalid_data)
        else $error("stack written while on");
    a_count_refused: assert property (wr_ec && cmd_wdata[3:0] > SSC_FC_MAX
        |=> invalid_data) else $error("bad count taken");
    a_count_range: assert property (follower_count <= SSC_FC_MAX)
        else $error("count out of range");
    a_upper_zero: assert property (cmd_ack && $past(cmd_rd && cmd_code ==
        SSC_CMD_PHASE_STACK) |-> cmd_rdata[15:4] == 12'h000)
        else $error("stack upper bits set");
    a_follow_quiet: assert property (following |-> !sync_oe)
        else $error("drives pin while following");
    a_follower_role: assert property ((is_follower && conv_enable) [*4]
        |-> following) else $error("follower not following");
    a_back_fixed: assert property (cmd_ack |-> $stable(backchannel_en))
        else $error("backchannel changed by write");
    c_refused: cover property (cmd_ack && invalid_data);
    c_fault: cover property ($rose(sync_fault));
    c_follow: cover property ($rose(following));
endmodule // ssc_monitor
bind ssc_sync_stack_config ssc_monitor u_mon (.core_clk, .rst_n, .clk_en,
    .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack,
    .invalid_data, .conv_enable, .is_follower, .sync_oe, .sync_fault,
    .following, .backchannel_en, .follower_count);
`default_nettype wire

// ### ssc_sync_source.sv
// External sync clock source on the far side of the sync pin
`timescale 1ns/100ps
`default_nettype none
module ssc_sync_source (
    // Control
    input wire logic run,
    // Pin
    output logic pin
);
    // 200 ns link clock, quiet low between runs
    always begin
        pin = 1'b0;
        wait (run);
        while (run) begin
            #100 pin = ~pin;
        end
    end
endmodule // ssc_sync_source
`default_nettype wire

// ### test_sync_stack_config.sv
// Self-checking bench for the sync and stack configuration block
`timescale 1ns/100ps
`default_nettype none
module test_sync_stack_config;
    import ssc_pkg::*;
    typedef struct packed {
        logic [7:0] code;
        logic word;
        logic [15:0] wd;
        logic inv;
        logic [15:0] rd;
    } ssc_row_type;
    ssc_row_type rows [11] = '{
        '{8'he4, 1'b0, 16'h0090, 1'b0, 16'h0090},
        '{8'he4, 1'b0, 16'h0050, 1'b0, 16'h0050},
        '{8'he4, 1'b0, 16'h0070, 1'b0, 16'h0070},
        '{8'he4, 1'b0, 16'h0091, 1'b1, 16'h0070},
        '{8'he4, 1'b1, 16'h00f0, 1'b1, 16'h0070},
        '{8'he4, 1'b0, 16'h00f0, 1'b0, 16'h00f0},
        '{8'hec, 1'b1, 16'h0003, 1'b0, 16'h0003},
        '{8'hec, 1'b1, 16'h0004, 1'b1, 16'h0003},
        '{8'hec, 1'b1, 16'h0013, 1'b1, 16'h0003},
        '{8'hec, 1'b0, 16'h0001, 1'b1, 16'h0003},
        '{8'hec, 1'b1, 16'h0000, 1'b0, 16'h0000}};
    logic core_clk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0;
    logic cmd_word = 1'b0, conv_enable = 1'b0, is_follower = 1'b0;
    logic src_run = 1'b0, prev = 1'b0, low_limit = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [3:0] strap = 4'h2;
    logic [15:0] cmd_rdata;
    logic [3:0] follower_count;
    logic cmd_ack, invalid_data, sync_out, sync_oe, sync_fault, following;
    logic slow_osc, backchannel_en, src_pin, sync_pin;
    int num_errors = 0, checks = 0, cycles = 0, n = 0;
    always #12.5 core_clk = ~core_clk;
    assign sync_pin = sync_oe ? sync_out : src_pin;
    ssc_sync_source u_src (.run(src_run), .pin(src_pin));
    ssc_sync_stack_config uut (.core_clk, .rst_n, .clk_en(1'b1), .cmd_wr,
        .cmd_rd, .cmd_code, .cmd_word, .cmd_wdata, .cmd_rdata, .cmd_ack,
        .invalid_data, .conv_enable, .is_follower, .at_low_limit(low_limit),
        .strap_follower_count(strap), .sync_in(sync_pin), .sync_high(1'b0),
        .sync_out, .sync_oe, .sync_fault, .following, .slow_osc,
        .backchannel_en, .follower_count);
    task automatic chk_bit(string name, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_word(string name, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic access(logic wr, logic [7:0] code, logic wd16,
        logic [15:0] wd);
        @(posedge core_clk);
        cmd_wr <= wr;
        cmd_rd <= !wr;
        cmd_code <= code;
        cmd_word <= wd16;
        cmd_wdata <= wd;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
        #1;
        chk_bit("ack", 1'b1, cmd_ack);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 12000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        access(0, SSC_CMD_CLOCK_SYNC, 0, 0);
        chk_word("sync reset", 16'h0050, cmd_rdata);
        access(0, SSC_CMD_PHASE_STACK, 1, 0);
        chk_word("stack strap", 16'h0002, cmd_rdata);
        chk_bit("backchannel on", 1'b1, backchannel_en);
        foreach (rows[i]) begin
            access(1, rows[i].code, rows[i].word, rows[i].wd);
            chk_bit("invalid", rows[i].inv, invalid_data);
            access(0, rows[i].code, rows[i].code == 8'hec, 0);
            chk_word("readback", rows[i].rd, cmd_rdata);
        end
        access(0, 8'he3, 1, 0);
        chk_bit("unmapped", 1'b1, invalid_data);
        conv_enable <= 1'b1;
        repeat (300) @(posedge core_clk);
        chk_bit("auto quiet", 1'b1, sync_oe & !following);
        @(negedge core_clk);
        prev = sync_out;
        repeat (800) begin
            @(negedge core_clk);
            if (sync_out && !prev) n++;
            prev = sync_out;
        end
        chk_word("pulses", 16'h000a, 16'(n));
        access(1, SSC_CMD_PHASE_STACK, 1, 16'h0001);
        chk_bit("stack locked", 1'b1, invalid_data);
        conv_enable <= 1'b0;
        src_run <= 1'b1;
        repeat (40) @(posedge core_clk);
        conv_enable <= 1'b1;
        repeat (300) @(posedge core_clk);
        chk_bit("auto toggling", 1'b1, following & !sync_oe);
        conv_enable <= 1'b0;
        src_run <= 1'b0;
        is_follower <= 1'b1;
        access(1, SSC_CMD_CLOCK_SYNC, 0, 16'h00b0);
        conv_enable <= 1'b1;
        repeat (400) @(posedge core_clk);
        chk_bit("lost clock", 1'b1, sync_fault);
        access(1, SSC_CMD_CLOCK_SYNC, 0, 16'h0070);
        repeat (5) @(posedge core_clk);
        chk_bit("slow osc", 1'b1, slow_osc);
        conv_enable <= 1'b0;
        is_follower <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk_bit("slow cleared", 1'b0, slow_osc);
        access(1, SSC_CMD_CLOCK_SYNC, 0, 16'h00b0);
        conv_enable <= 1'b1;
        access(1, SSC_CMD_CLOCK_SYNC, 0, 16'h0070);
        repeat (2) @(posedge core_clk);
        chk_bit("full rate", 1'b0, slow_osc);
        access(1, SSC_CMD_CLOCK_SYNC, 0, 16'h00b0);
        low_limit <= 1'b1;
        access(1, SSC_CMD_CLOCK_SYNC, 0, 16'h0070);
        repeat (2) @(posedge core_clk);
        chk_bit("low limit", 1'b1, slow_osc);
        low_limit <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk_bit("rate kept", 1'b1, slow_osc);
        conv_enable <= 1'b0;
        strap <= 4'h0;
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk_bit("backchannel off", 1'b0, backchannel_en);
        access(1, SSC_CMD_PHASE_STACK, 1, 16'h0001);
        chk_word("count", 16'h0001, 16'(follower_count));
        chk_bit("backchannel held", 1'b0, backchannel_en);
        strap <= 4'h1;
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk_bit("backchannel after cycle", 1'b1, backchannel_en);
        access(1, SSC_CMD_PHASE_STACK, 1, 16'h0003);
        chk_word("live count", 16'h0003, 16'(follower_count));
        chk_bit("backchannel kept", 1'b1, backchannel_en);
        print_verdict();
    end
endmodule // test_sync_stack_config
`default_nettype wire
